// ==== dv/udw_host_asserts.sv ====
// Pin protocol checks for the wiper host
`timescale 1ns/1ps
module udw_host_asserts
  import udw_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  input udw_pins_t       potPins,
  input wire logic [4:0] trackPos,
  input wire logic [4:0] storedPos
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  AST_UP: assert property (
    $fell(potPins.stepN) && !potPins.selN && potPins.upDir |-> trackPos ==
    ($past(trackPos) == POS_TOP ? POS_TOP : $past(trackPos) + 5'h01)) else $error("bad up");
  AST_DN: assert property (
    $fell(potPins.stepN) && !potPins.selN && !potPins.upDir |-> trackPos ==
    ($past(trackPos) == POS_BOTTOM ? POS_BOTTOM : $past(trackPos) - 5'h01)) else $error("bad dn");
  AST_ST: assert property (
    $rose(potPins.selN) && potPins.stepN |-> storedPos == trackPos) else $error("bad store");
  AST_NS: assert property (
    $rose(potPins.selN) && !potPins.stepN |-> $stable(storedPos)) else $error("bad nostore");
  AST_ONEPIN: assert property (
    $changed(potPins.selN) |-> $stable(potPins.stepN)) else $error("pins moved together");
endmodule : udw_host_asserts
bind udw_host udw_host_asserts udw_host_asserts_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .potPins(potPins), .trackPos(trackPos), .storedPos(storedPos));

// ==== dv/udw_host_bench.sv ====
// Bench for the wiper host
`timescale 1ns/1ps
module udw_host_bench;
  import udw_pkg::*;
  logic        ref_clk = 1'b0, sys_rst = 1'b1, cmdValid = 1'b0;
  logic [1:0]  cmdCode = 2'h0;
  logic        cmdReady, cmdDone;
  udw_pins_t   potPins;
  logic [4:0]  trackPos, storedPos, wiperPos, nvPos, expPos, expNv;
  logic [31:0] tapSel;
  int          badCount = 0, checkCount = 0;
  udw_host udw_host_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmdValid(cmdValid),
    .cmdCode(cmdCode), .cmdReady(cmdReady), .cmdDone(cmdDone), .potPins(potPins),
    .trackPos(trackPos), .storedPos(storedPos));
  udw_pot_model udw_pot_model_inst (.pins(potPins), .wiperPos(wiperPos), .nvPos(nvPos),
    .tapSel(tapSel));
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic endSim();
    $display("checks %0d bad %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : endSim
  // Waits read pre-edge values, so no race with the design
  task automatic run(logic [1:0] code);
    int n;
    n = 0;
    cmdValid <= 1'b1;
    cmdCode  <= code;
    @(posedge ref_clk);
    while (cmdReady !== 1'b1 && n < 100)
    begin
      @(posedge ref_clk);
      n++;
    end
    // Taken at this edge; withdrawn right after it
    cmdValid <= 1'b0;
    n = 0;
    @(posedge ref_clk);
    while (cmdDone !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (cmdDone !== 1'b1 || cmdReady !== 1'b1)
    begin
      badCount++;
      $display("[FAIL] %0t timeout", $time);
      endSim();
    end
  endtask : run
  task automatic chk(string msg);
    checkCount++;
    if ((trackPos === expPos && wiperPos === expPos && tapSel === 32'h1 << expPos &&
        storedPos === expNv && nvPos === expNv) !== 1'b1)
    begin
      badCount++;
      $display("[FAIL] %0t %s pos %h nv %h", $time, msg, wiperPos, nvPos);
    end
  endtask : chk
  task automatic t_floor();
    run(CMD_STEP_DOWN);
    chk("floor");
    $display("floor done");
  endtask : t_floor
  task automatic t_climb();
    repeat (33)
    begin
      run(CMD_STEP_UP);
      if (expPos != POS_TOP) expPos = expPos + 5'h01;
      chk("climb");
    end
    $display("climb done");
  endtask : t_climb
  task automatic t_store();
    run(CMD_STORE);
    expNv = expPos;
    chk("store");
    $display("store done");
  endtask : t_store
  task automatic t_trial();
    run(CMD_STEP_DOWN);
    run(CMD_STEP_DOWN);
    run(CMD_DESELECT);
    expPos = expPos - 5'h02;
    chk("trial");
    $display("trial done");
  endtask : t_trial
  initial
  begin
    expPos = POS_RESET;
    expNv = POS_RESET;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_floor();
    t_climb();
    t_store();
    t_trial();
    endSim();
  end
endmodule : udw_host_bench

// ==== dv/udw_pot_model.sv ====
// Pin-level model of the wiper pot
`timescale 1ns/1ps
module udw_pot_model
  import udw_pkg::*;
(
  input udw_pins_t    pins,
  output logic [4:0]  wiperPos,
  output logic [4:0]  nvPos,
  output logic [31:0] tapSel
);
  initial
  begin
    nvPos = POS_RESET;
    wiperPos = nvPos;
  end
  assign tapSel = 32'h1 << wiperPos;
  always @(negedge pins.stepN)
    if (!pins.selN && pins.upDir && wiperPos != POS_TOP) wiperPos <= wiperPos + 5'h01;
    else if (!pins.selN && !pins.upDir && wiperPos != POS_BOTTOM) wiperPos <= wiperPos - 5'h01;
  always @(posedge pins.selN)
    if (pins.stepN === 1'b1) nvPos <= wiperPos;
endmodule : udw_pot_model

// ==== rtl/udw_host.sv ====
// Host controller driving select, direction and step pins of a wiper pot
`timescale 1ns/1ps

// How it works
// - Select low, direction high, falling step moves wiper toward high terminal.
// - Select low, direction low, falling step moves wiper toward low terminal.
// - Select rising while step high stores the counter.
// - Select rising while step low deselects without storing.
module udw_host
  import udw_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  input  wire logic       cmdValid,
  input  wire logic [1:0] cmdCode,
  output logic            cmdReady,
  output logic            cmdDone,
  output udw_pins_t       potPins,
  output logic [4:0]      trackPos,
  output logic [4:0]      storedPos
);

  udw_state_t  state_reg, state_next;
  logic [3:0]  cnt_reg, cnt_next;
  logic [1:0]  cmd_reg, cmd_next;
  udw_pins_t   pins_reg, pins_next;
  // Mirrors only: the device has no read-back path
  logic [4:0]  pos_reg, pos_next;
  logic [4:0]  stored_reg, stored_next;
  logic        ready_reg, ready_next;
  logic        done_reg, done_next;

  function automatic logic [4:0] udwStep(input logic [4:0] p, input logic up);
    if (up)
      udwStep = (p == POS_TOP) ? p : 5'(p + 5'h01);
    else
      udwStep = (p == POS_BOTTOM) ? p : 5'(p - 5'h01);
  endfunction : udwStep

  // Phase timer wraps itself; only idle holds it at zero
  wire phaseEnd = (cnt_reg == PHASE_LAST);
  wire isStep   = (cmd_reg == CMD_STEP_UP) || (cmd_reg == CMD_STEP_DOWN);
  wire isUp     = (cmd_reg == CMD_STEP_UP);
  wire isStore  = (cmd_reg == CMD_STORE);
  wire take     = ready_reg && cmdValid;

  // Launch levels for a newly taken command
  wire newDesel = (cmdCode == CMD_DESELECT);
  wire newUp    = (cmdCode == CMD_STEP_UP);
  // Deselect drops the strobe under standby, so that edge is ignored
  wire newSelN  = newDesel;
  wire newStepN = ~newDesel;

  // Select and strobe change one at a time, each held a full phase; direction changes with select at launch
  always_comb
  begin
    state_next  = state_reg;
    cnt_next    = phaseEnd ? 4'h0 : 4'(cnt_reg + 4'h1);
    cmd_next    = cmd_reg;
    pins_next   = pins_reg;
    pos_next    = pos_reg;
    stored_next = stored_reg;
    ready_next  = 1'b0;
    done_next   = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        cnt_next   = 4'h0;
        ready_next = ~take;
        if (take)
        begin
          cmd_next  = cmdCode;
          state_next = ST_SETUP;
          // direction settles a full phase before the step
          pins_next.selN  = newSelN;
          pins_next.upDir = newUp;
          // strobe low before select drops for a deselect
          pins_next.stepN = newStepN;
        end
      end
      ST_SETUP:
        if (phaseEnd)
        begin
          if (isStep)
          begin
            pins_next.stepN = 1'b0;
            pos_next        = udwStep(pos_reg, isUp);
            state_next      = ST_LOW;
          end
          else if (isStore)
          begin
            pins_next.selN = 1'b1;
            stored_next    = pos_reg;
            state_next     = ST_RISE;
          end
          else
          begin
            // select drops with the strobe already low
            pins_next.selN = 1'b0;
            state_next     = ST_LOW;
          end
        end
      ST_LOW:
        if (phaseEnd)
        begin
          // select rises while strobe low, nothing stored
          pins_next.selN = 1'b1;
          state_next     = ST_HIGH;
        end
      ST_HIGH:
        if (phaseEnd)
        begin
          // strobe returns high under standby, so it never steps
          pins_next.stepN = 1'b1;
          state_next      = ST_RISE;
        end
      ST_RISE:
        if (phaseEnd)
        begin
          pins_next.selN = 1'b1;
          state_next     = ST_RELAX;
        end
      ST_RELAX:
        if (phaseEnd)
        begin
          // Ready returns together with the done pulse
          pins_next  = PINS_IDLE;
          done_next  = 1'b1;
          ready_next = 1'b1;
          state_next = ST_IDLE;
        end
      default:
      begin
        state_next = ST_IDLE;
        pins_next  = PINS_IDLE;
      end
    endcase
  end

  // Sequencer state and latched command
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      state_reg <= ST_IDLE;
      cmd_reg   <= CMD_DESELECT;
    end
    else
    begin
      state_reg <= state_next;
      cmd_reg   <= cmd_next;
    end
  end

  // Phase timer
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      cnt_reg <= 4'h0;
    end
    else
    begin
      cnt_reg <= cnt_next;
    end
  end

  // Pin drivers, registered so the pins never glitch
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      pins_reg <= PINS_IDLE;
    end
    else
    begin
      pins_reg <= pins_next;
    end
  end

  // Mirrors of the device counter and its stored copy
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      // mirror starts at assumed recalled value
      pos_reg    <= POS_RESET;
      stored_reg <= POS_RESET;
    end
    else
    begin
      pos_reg    <= pos_next;
      stored_reg <= stored_next;
    end
  end

  // Command handshake
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ready_reg <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      ready_reg <= ready_next;
      done_reg  <= done_next;
    end
  end

  assign cmdReady  = ready_reg;
  assign cmdDone   = done_reg;
  assign potPins   = pins_reg;
  assign trackPos  = pos_reg;
  assign storedPos = stored_reg;

endmodule : udw_host

// ==== shared/udw_pkg.sv ====
// Package for the up/down wiper host controller
package udw_pkg;

  // Wiper geometry
  localparam int          TAP_COUNT  = 32;
  localparam int          ELEM_COUNT = 31;
  localparam int          POS_W      = 5;
  localparam logic [4:0]  POS_TOP    = 5'h1F;
  localparam logic [4:0]  POS_BOTTOM = 5'h00;
  localparam logic [4:0]  POS_RESET  = 5'h00;

  // Pin phase length in ref_clk cycles (setup, strobe low, strobe high, rise, relax)
  localparam int          PHASE_NS     = 50;
  localparam int          CLK_NS       = 5;
  localparam int          PHASE_CYC    = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0]  PHASE_LAST   = 4'(PHASE_CYC - 1);

  // Command codes
  localparam logic [1:0]  CMD_STEP_UP   = 2'h0;
  localparam logic [1:0]  CMD_STEP_DOWN = 2'h1;
  localparam logic [1:0]  CMD_STORE     = 2'h2;
  localparam logic [1:0]  CMD_DESELECT  = 2'h3;

  typedef struct packed {
    logic       selN;
    logic       upDir;
    logic       stepN;
  } udw_pins_t;

  localparam udw_pins_t PINS_IDLE = '{selN: 1'b1, upDir: 1'b0, stepN: 1'b1};

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_LOW    = 3'b010,
    ST_HIGH   = 3'b011,
    ST_RISE   = 3'b100,
    ST_RELAX  = 3'b101
  } udw_state_t;

endpackage : udw_pkg
